/* design/fpa_cfg.svh */
// Purpose: Offsets, field positions, reset values and codes for the adder
// Assumes: Included by bare name, definitions only
// Notes: Byte addresses on the register bus
`ifndef FPA_CFG_SVH
`define FPA_CFG_SVH
`define FPA_OFS_INSTR 12'h000
`define FPA_OFS_FLAGS 12'h004
`define FPA_OFS_CR0 12'h008
`define FPA_GENREG_PAGE 5'h01
`define FPA_OPC_ADDI 6'h0E
`define FPA_OPC_ADDIC 6'h0C
`define FPA_OPC_ADDIC_REC 6'h0D
`define FPA_OPC_EXT 6'h1F
`define FPA_XO_ADDE 9'h08A
`define FPA_OPC_HI 31
`define FPA_OPC_LO 26
`define FPA_TGT_HI 25
`define FPA_TGT_LO 21
`define FPA_BASE_HI 20
`define FPA_BASE_LO 16
`define FPA_SRC2_HI 15
`define FPA_SRC2_LO 11
`define FPA_OE_BIT 10
`define FPA_XO_HI 9
`define FPA_XO_LO 1
`define FPA_REC_BIT 0
`define FPA_IMM_HI 15
`define FPA_FLG_CARRY 0
`define FPA_FLG_OVF 1
`define FPA_FLG_SO 2
`define FPA_CR_NEG 3
`define FPA_CR_POS 2
`define FPA_CR_ZERO 1
`define FPA_CR_SO 0
`define FPA_INSTR_RST 32'h0000_0000
`define FPA_CR0_RST 4'h0
`define FPA_RESP_OKAY 2'h0
`define FPA_RESP_SLVERR 2'h2
`endif

/* design/fpa_pkg.sv */
// Purpose: Types shared by the adder datapath
// Assumes: Constants live in fpa_cfg.svh
// Notes: None
package fpa_pkg;
    typedef enum logic [2:0] {
        FPA_OP_NONE,
        FPA_OP_ADDI,
        FPA_OP_ADDIC,
        FPA_OP_ADDIC_REC,
        FPA_OP_ADDE
    } fpa_op_t;
endpackage

/* design/fpa_add_imm_unit.sv */
// Purpose: Fixed-point add-immediate and extended add datapath
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes: Writing the instruction word executes it in that same cycle
// Functional notes
// - Register operands are 32-bit two's complement integers.
// - Opcode 14 adds sign-extended immediate to base, writes target.
// - Opcode 14 with base field 0 uses zero as base.
// - Opcode 14 leaves carry, overflow, summary overflow, field 0 alone.
// - Opcode 12 adds base plus extended immediate; field 0 is real.
// - Immediate is fully sign-extended before the add and carry.
// - Opcode 12 updates carry and never touches field 0.
// - Opcode 13 does the same and also sets field 0.
// - Opcode 13 decoded; target, source, immediate from fixed bit fields.
// - Extended add sums two registers and the carry flag.
// - Register forms: carry always, overflow on enable, field 0 on record.
`timescale 1ns/1ns
`include "fpa_cfg.svh"
module fpa_add_imm_unit
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic [2:0] awprot,
    // Write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // Write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // Read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    input wire logic [2:0] arprot,
    // Read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);

    function automatic logic [31:0] merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] sext(input logic [15:0] v);
        return {{16{v[`FPA_IMM_HI]}}, v};
    endfunction

    logic [31:0] general_register_mem [0:31];
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, w_data_reg, instr_reg;
    logic [11:0] aw_addr_reg;
    logic [3:0] w_strb_reg, cr0_reg;
    logic aw_hold_reg, w_hold_reg, carry_flag_reg, overflow_flag_reg;
    logic so_reg;
    logic do_write, wr_instr, wr_flags, wr_cr0, wr_general_register, exec;
    logic [31:0] word, opa, opb, sum, rd_value;
    logic [4:0] target_reg_field, base_reg_field, second_src_reg_field;
    logic [15:0] imm;
    logic oe, record_bit, cin, cout, ovf, so_new;
    logic [32:0] sum33;
    fpa_pkg::fpa_op_t op_kind;

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // Write channel decode
    assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_instr = do_write && aw_addr_reg == `FPA_OFS_INSTR;
    assign wr_flags = do_write && aw_addr_reg == `FPA_OFS_FLAGS;
    assign wr_cr0 = do_write && aw_addr_reg == `FPA_OFS_CR0;
    assign wr_general_register = do_write &&
        aw_addr_reg[11:7] == `FPA_GENREG_PAGE;

    // Instruction fields
    assign word = merge(instr_reg, w_data_reg, w_strb_reg);
    assign target_reg_field = word[`FPA_TGT_HI:`FPA_TGT_LO];
    assign base_reg_field = word[`FPA_BASE_HI:`FPA_BASE_LO];
    assign second_src_reg_field = word[`FPA_SRC2_HI:`FPA_SRC2_LO];
    assign imm = word[`FPA_IMM_HI:0];
    assign oe = word[`FPA_OE_BIT];
    assign record_bit = word[`FPA_REC_BIT];

    always_comb
    begin
        case (word[`FPA_OPC_HI:`FPA_OPC_LO])
            `FPA_OPC_ADDI: op_kind = fpa_pkg::FPA_OP_ADDI;
            `FPA_OPC_ADDIC: op_kind = fpa_pkg::FPA_OP_ADDIC;
            `FPA_OPC_ADDIC_REC: op_kind = fpa_pkg::FPA_OP_ADDIC_REC;
            `FPA_OPC_EXT:
                op_kind = (word[`FPA_XO_HI:`FPA_XO_LO] == `FPA_XO_ADDE)
                    ? fpa_pkg::FPA_OP_ADDE : fpa_pkg::FPA_OP_NONE;
            default: op_kind = fpa_pkg::FPA_OP_NONE;
        endcase
    end

    // Unknown words are stored but do nothing else
    assign exec = wr_instr && op_kind != fpa_pkg::FPA_OP_NONE;

    // Operand selection and the one shared adder
    always_comb
    begin
        if (op_kind == fpa_pkg::FPA_OP_ADDI && base_reg_field == 5'h00)
        begin
            opa = 32'h0000_0000;
        end
        else
        begin
            opa = general_register_mem[base_reg_field];
        end
        if (op_kind == fpa_pkg::FPA_OP_ADDE)
        begin
            opb = general_register_mem[second_src_reg_field];
            cin = carry_flag_reg;
        end
        else
        begin
            opb = sext(imm);
            cin = 1'b0;
        end
    end

    assign sum33 = {1'b0, opa} + {1'b0, opb} + {32'h0000_0000, cin};
    assign sum = sum33[31:0];
    assign cout = sum33[32];
    // Sign test stays valid with carry-in since it adds at most one
    assign ovf = (opa[31] == opb[31]) && (sum[31] != opa[31]);
    assign so_new = so_reg | (op_kind == fpa_pkg::FPA_OP_ADDE && oe && ovf);

    // General registers, no reset: software loads them before use
    always_ff @(posedge aclk)
    begin
        if (exec)
        begin
            general_register_mem[target_reg_field] <= sum;
        end
        else if (wr_general_register)
        begin
            general_register_mem[aw_addr_reg[6:2]] <= merge(
                general_register_mem[aw_addr_reg[6:2]], w_data_reg,
                w_strb_reg);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            instr_reg <= `FPA_INSTR_RST;
        end
        else if (wr_instr)
        begin
            instr_reg <= word;
        end
    end

    // Exception flags; address add leaves them alone
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            carry_flag_reg <= 1'b0;
            overflow_flag_reg <= 1'b0;
            so_reg <= 1'b0;
        end
        else if (exec && op_kind != fpa_pkg::FPA_OP_ADDI)
        begin
            carry_flag_reg <= cout;
            if (op_kind == fpa_pkg::FPA_OP_ADDE && oe)
            begin
                overflow_flag_reg <= ovf;
                so_reg <= so_new;
            end
        end
        else if (wr_flags)
        begin
            carry_flag_reg <= w_data_reg[`FPA_FLG_CARRY];
            overflow_flag_reg <= w_data_reg[`FPA_FLG_OVF];
            so_reg <= w_data_reg[`FPA_FLG_SO];
        end
    end

    // Condition field 0
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cr0_reg <= `FPA_CR0_RST;
        end
        else if (exec && (op_kind == fpa_pkg::FPA_OP_ADDIC_REC ||
            (op_kind == fpa_pkg::FPA_OP_ADDE && record_bit)))
        begin
            cr0_reg[`FPA_CR_NEG] <= sum[31];
            cr0_reg[`FPA_CR_POS] <= !sum[31] && sum != 32'h0000_0000;
            cr0_reg[`FPA_CR_ZERO] <= sum == 32'h0000_0000;
            cr0_reg[`FPA_CR_SO] <= so_new;
        end
        else if (wr_cr0)
        begin
            cr0_reg <= w_data_reg[3:0];
        end
    end

    // Write address and data are taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg <= 1'b0;
            awready_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
        end
        else if (awvalid && awready_reg)
        begin
            aw_hold_reg <= 1'b1;
            awready_reg <= 1'b0;
            aw_addr_reg <= {awaddr[11:2], 2'h0};
        end
        else if (do_write)
        begin
            aw_hold_reg <= 1'b0;
        end
        else if (!aw_hold_reg && !bvalid_reg)
        begin
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_hold_reg <= 1'b0;
            wready_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end
        else if (wvalid && wready_reg)
        begin
            w_hold_reg <= 1'b1;
            wready_reg <= 1'b0;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
        end
        else if (do_write)
        begin
            w_hold_reg <= 1'b0;
        end
        else if (!w_hold_reg && !bvalid_reg)
        begin
            wready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `FPA_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_instr || wr_flags || wr_cr0 ||
                wr_general_register) ? `FPA_RESP_OKAY : `FPA_RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read side
    always_comb
    begin
        rd_value = 32'h0000_0000;
        if (araddr[11:7] == `FPA_GENREG_PAGE)
        begin
            rd_value = general_register_mem[araddr[6:2]];
        end
        else if ({araddr[11:2], 2'h0} == `FPA_OFS_INSTR)
        begin
            rd_value = instr_reg;
        end
        else if ({araddr[11:2], 2'h0} == `FPA_OFS_FLAGS)
        begin
            rd_value[`FPA_FLG_CARRY] = carry_flag_reg;
            rd_value[`FPA_FLG_OVF] = overflow_flag_reg;
            rd_value[`FPA_FLG_SO] = so_reg;
        end
        else if ({araddr[11:2], 2'h0} == `FPA_OFS_CR0)
        begin
            rd_value[3:0] = cr0_reg;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `FPA_RESP_OKAY;
        end
        else if (arvalid && arready_reg)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_value;
            rresp_reg <= (araddr[11:7] == `FPA_GENREG_PAGE ||
                {araddr[11:4], 2'h0} == 10'h000 && araddr[3:2] != 2'h3)
                ? `FPA_RESP_OKAY : `FPA_RESP_SLVERR;
        end
        else if (rvalid_reg && rready)
        begin
            rvalid_reg <= 1'b0;
        end
        else if (!rvalid_reg)
        begin
            arready_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_addi_zero_base: assert property (
        exec && op_kind == fpa_pkg::FPA_OP_ADDI && base_reg_field == 5'h00
        |=> general_register_mem[$past(target_reg_field)]
            == sext($past(imm)))
        else $error("address add with base 0 did not give the immediate");

    a_addi_sum_value: assert property (
        exec && op_kind == fpa_pkg::FPA_OP_ADDI && base_reg_field != 5'h00
        |=> general_register_mem[$past(target_reg_field)]
            - $past(general_register_mem[base_reg_field])
            == sext($past(imm)))
        else $error("address add result wrong");

    a_addi_flags_kept: assert property (
        exec && op_kind == fpa_pkg::FPA_OP_ADDI
        |=> $stable(carry_flag_reg) && $stable(overflow_flag_reg)
            && $stable(so_reg) && $stable(cr0_reg))
        else $error("address add changed a flag");

    a_addic_real_reg0: assert property (
        exec && op_kind == fpa_pkg::FPA_OP_ADDIC && base_reg_field == 5'h00
        |=> general_register_mem[$past(target_reg_field)]
            == $past(general_register_mem[0]) + sext($past(imm)))
        else $error("carrying add did not use register 0");

    a_imm_carry_out: assert property (
        exec && op_kind == fpa_pkg::FPA_OP_ADDIC
        |=> carry_flag_reg == (general_register_mem[$past(target_reg_field)]
            < $past(general_register_mem[base_reg_field]))
            && !$changed(cr0_reg))
        else $error("carrying add carry or field 0 wrong");

    a_rec_cr0_set: assert property (
        exec && op_kind == fpa_pkg::FPA_OP_ADDIC_REC
        |=> cr0_reg[`FPA_CR_NEG]
            == general_register_mem[$past(target_reg_field)][31]
            && cr0_reg[`FPA_CR_ZERO]
            == (general_register_mem[$past(target_reg_field)] == 32'h0)
            && cr0_reg[`FPA_CR_POS] == !(cr0_reg[`FPA_CR_NEG]
            || cr0_reg[`FPA_CR_ZERO])
            && cr0_reg[`FPA_CR_SO] == so_reg)
        else $error("record form field 0 wrong");

    a_adde_sum_cin: assert property (
        exec && op_kind == fpa_pkg::FPA_OP_ADDE
        |=> general_register_mem[$past(target_reg_field)] == 32'(
            $past(general_register_mem[base_reg_field])
            + $past(general_register_mem[second_src_reg_field])
            + {31'h0, $past(carry_flag_reg)}))
        else $error("extended add result wrong");

    a_adde_ov_gate: assert property (
        exec && op_kind == fpa_pkg::FPA_OP_ADDE && !oe && !record_bit
        |=> $stable(overflow_flag_reg) && $stable(so_reg) && $stable(cr0_reg))
        else $error("extended add without enables changed flags");

endmodule // fpa_add_imm_unit

/* dv/fpa_axi_master.sv */
// Purpose: AXI4-Lite master standing in for the issue logic
// Assumes: Slave answers by handshake; no fixed latency assumed
// Notes: Released address and data lines show the inverse value
`timescale 1ns/1ns
module fpa_axi_master
(
    // Clock
    input wire logic aclk,
    // Write channels
    output logic awvalid,
    input wire logic awready,
    output logic [11:0] awaddr,
    output logic [2:0] awprot,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    // Read channels
    output logic arvalid,
    input wire logic arready,
    output logic [11:0] araddr,
    output logic [2:0] arprot,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, awprot, arprot} = 30'h0;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (awvalid && awready)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        // Answer may come late; only the bench timeout ends this wait
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule // fpa_axi_master

/* dv/fpa_add_imm_unit_bench.sv */
// Purpose: Self-checking bench for the add-immediate datapath
// Assumes: Instruction word write executes it; results read back
// Notes: Expected sums worked out by hand from the operands
`timescale 1ns/1ns
`include "fpa_cfg.svh"
module fpa_add_imm_unit_bench;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rr;
    int n_mismatch, num_checks, cyc;
    fpa_add_imm_unit fpa_add_imm_unit_inst (.aclk, .aresetn, .awvalid,
        .awready, .awaddr, .awprot, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
        .rvalid, .rready, .rdata, .rresp);
    fpa_axi_master fpa_axi_master_inst (.aclk, .awvalid, .awready,
        .awaddr, .awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
        .rready, .rdata, .rresp);
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    function automatic logic [11:0] g(input logic [4:0] n);
        g = {`FPA_GENREG_PAGE, n, 2'h0};
    endfunction
    function automatic logic [31:0] di(input logic [5:0] o,
        input logic [4:0] t, input logic [4:0] a, input logic [15:0] i);
        di = {o, t, a, i};
    endfunction
    function automatic logic [31:0] xi(input logic [4:0] t,
        input logic [4:0] a, input logic [4:0] b, input logic oe,
        input logic rec);
        xi = {`FPA_OPC_EXT, t, a, b, oe, `FPA_XO_ADDE, rec};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] s);
        num_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chkr(input string nm, input logic [1:0] e,
        input logic [1:0] s);
        num_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic w(input logic [11:0] a, input logic [31:0] d);
        fpa_axi_master_inst.wr(a, d, 4'hF, rr);
        chkr("bresp", `FPA_RESP_OKAY, rr);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        fpa_axi_master_inst.rd(a, rv, rr);
        chkr("rresp", `FPA_RESP_OKAY, rr);
        chk($sformatf("read %h", a), e, rv);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Whole run needs a few hundred cycles; this only catches a hang
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial
    begin
        aresetn = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(`FPA_OFS_INSTR, 32'h0000_0000);
        rdc(`FPA_OFS_FLAGS, 32'h0000_0000);
        rdc(`FPA_OFS_CR0, 32'h0000_0000);
        fpa_axi_master_inst.wr(12'h040, 32'hFFFF_FFFF, 4'hF, rr);
        chkr("unmapped bresp", `FPA_RESP_SLVERR, rr);
        fpa_axi_master_inst.rd(12'h040, rv, rr);
        chkr("unmapped rresp", `FPA_RESP_SLVERR, rr);
        chk("unmapped rdata", 32'h0000_0000, rv);
        w(g(5'h01), 32'h1122_3344);
        fpa_axi_master_inst.wr(g(5'h01), 32'h0000_AB00, 4'h2, rr);
        rdc(g(5'h01), 32'h1122_AB44);
        w(`FPA_OFS_FLAGS, 32'h0000_0007);
        w(`FPA_OFS_CR0, 32'h0000_000A);
        w(g(5'h05), 32'h0000_0900);
        w(`FPA_OFS_INSTR, di(`FPA_OPC_ADDI, 5'h04, 5'h05, 16'h8FF0));
        rdc(g(5'h04), 32'hFFFF_98F0);
        w(g(5'h00), 32'h1234_5678);
        w(`FPA_OFS_INSTR, di(`FPA_OPC_ADDI, 5'h07, 5'h00, 16'h8000));
        rdc(g(5'h07), 32'hFFFF_8000);
        rdc(`FPA_OFS_FLAGS, 32'h0000_0007);
        rdc(`FPA_OFS_CR0, 32'h0000_000A);
        w(`FPA_OFS_FLAGS, 32'h0000_0000);
        w(g(5'h04), 32'h0000_2346);
        w(`FPA_OFS_INSTR, di(`FPA_OPC_ADDIC, 5'h06, 5'h04, 16'hFFFF));
        rdc(g(5'h06), 32'h0000_2345);
        rdc(`FPA_OFS_FLAGS, 32'h0000_0001);
        rdc(`FPA_OFS_CR0, 32'h0000_000A);
        w(`FPA_OFS_INSTR, di(`FPA_OPC_ADDIC, 5'h08, 5'h00, 16'h0001));
        rdc(g(5'h08), 32'h1234_5679);
        rdc(`FPA_OFS_FLAGS, 32'h0000_0000);
        w(g(5'h04), 32'hEFFF_FFFF);
        w(`FPA_OFS_INSTR, di(`FPA_OPC_ADDIC_REC, 5'h06, 5'h04, 16'h1000));
        rdc(g(5'h06), 32'hF000_0FFF);
        rdc(`FPA_OFS_FLAGS, 32'h0000_0000);
        rdc(`FPA_OFS_CR0, 32'h0000_0008);
        w(g(5'h03), 32'hFFFF_FFFF);
        w(`FPA_OFS_INSTR, di(`FPA_OPC_ADDIC_REC, 5'h09, 5'h03, 16'h0001));
        rdc(g(5'h09), 32'h0000_0000);
        rdc(`FPA_OFS_FLAGS, 32'h0000_0001);
        rdc(`FPA_OFS_CR0, 32'h0000_0002);
        w(`FPA_OFS_FLAGS, 32'h0000_0004);
        w(`FPA_OFS_INSTR, di(`FPA_OPC_ADDIC_REC, 5'h09, 5'h05, 16'h0100));
        rdc(g(5'h09), 32'h0000_0A00);
        rdc(`FPA_OFS_FLAGS, 32'h0000_0004);
        rdc(`FPA_OFS_CR0, 32'h0000_0005);
        w(`FPA_OFS_FLAGS, 32'h0000_0001);
        w(g(5'h04), 32'h1000_0400);
        w(g(5'h0A), 32'h1000_0400);
        w(`FPA_OFS_INSTR, xi(5'h06, 5'h04, 5'h0A, 1'b0, 1'b0));
        rdc(g(5'h06), 32'h2000_0801);
        rdc(`FPA_OFS_FLAGS, 32'h0000_0000);
        rdc(`FPA_OFS_CR0, 32'h0000_0005);
        w(`FPA_OFS_CR0, 32'h0000_0000);
        w(g(5'h04), 32'h9000_3000);
        w(g(5'h0A), 32'h8000_7000);
        w(`FPA_OFS_INSTR, xi(5'h06, 5'h04, 5'h0A, 1'b1, 1'b1));
        rdc(g(5'h06), 32'h1000_A000);
        rdc(`FPA_OFS_FLAGS, 32'h0000_0007);
        rdc(`FPA_OFS_CR0, 32'h0000_0005);
        rdc(`FPA_OFS_INSTR, xi(5'h06, 5'h04, 5'h0A, 1'b1, 1'b1));
        // Overflow enable alone: overflow clears, summary overflow sticks
        w(g(5'h04), 32'h1000_0400);
        w(g(5'h0A), 32'hEFFF_FFFF);
        w(`FPA_OFS_INSTR, xi(5'h06, 5'h04, 5'h0A, 1'b1, 1'b0));
        rdc(g(5'h06), 32'h0000_0400);
        rdc(`FPA_OFS_FLAGS, 32'h0000_0005);
        rdc(`FPA_OFS_CR0, 32'h0000_0005);
        // Record alone: field 0 updates, overflow bits stay
        w(`FPA_OFS_FLAGS, 32'h0000_0000);
        w(g(5'h04), 32'h9000_3000);
        w(g(5'h0A), 32'h7B41_92C0);
        w(`FPA_OFS_INSTR, xi(5'h06, 5'h04, 5'h0A, 1'b0, 1'b1));
        rdc(g(5'h06), 32'h0B41_C2C0);
        rdc(`FPA_OFS_FLAGS, 32'h0000_0001);
        rdc(`FPA_OFS_CR0, 32'h0000_0004);
        // Unknown opcode is stored and has no other effect
        w(`FPA_OFS_INSTR, di(6'h3F, 5'h06, 5'h04, 16'h0001));
        rdc(g(5'h06), 32'h0B41_C2C0);
        rdc(`FPA_OFS_INSTR, di(6'h3F, 5'h06, 5'h04, 16'h0001));
        rdc(`FPA_OFS_FLAGS, 32'h0000_0001);
        print_verdict();
    end
endmodule // fpa_add_imm_unit_bench
